// ===== src/tapcs_pkg.sv
package tapcs_pkg;

  // tap controller states, standard sixteen-state encoding
  typedef enum logic [3:0] {
    TAP_RESET   = 4'hF,
    TAP_IDLE    = 4'hC,
    TAP_SEL_DR  = 4'h7,
    TAP_CAP_DR  = 4'h6,
    TAP_SH_DR   = 4'h2,
    TAP_EX1_DR  = 4'h1,
    TAP_PAU_DR  = 4'h3,
    TAP_EX2_DR  = 4'h0,
    TAP_UPD_DR  = 4'h5,
    TAP_SEL_IR  = 4'h4,
    TAP_CAP_IR  = 4'hE,
    TAP_SH_IR   = 4'hA,
    TAP_EX1_IR  = 4'h9,
    TAP_PAU_IR  = 4'hB,
    TAP_EX2_IR  = 4'h8,
    TAP_UPD_IR  = 4'hD
  } tapcs_state_t;

  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam logic [IR_W-1:0] IR_RST      = 4'h1;
  localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;
  localparam logic [IR_W-1:0] IR_BYPASS   = 4'hF;
  localparam logic [IR_W-1:0] IR_IDCODE   = 4'h1;
  // identification value is arbitrary
  localparam logic [ID_W-1:0] ID_VALUE    = 32'h0000_0001;

  localparam int  CLK_PERIOD_NS = 8;
  localparam int  INIT_TIME_NS  = 256;
  localparam int  INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  INIT_CNT_W    = 6;
  localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(INIT_CYCLES - 1);

  // master-clock operating point: 0 = 19.2 MHz, 1 = 9.6 MHz
  localparam logic FSEL_19M2 = 1'b0;
  localparam logic FSEL_9M6  = 1'b1;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tapcs_pins_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } tapcs_tdo_t;

endpackage : tapcs_pkg

// ===== src/tapcs_top.sv
// Behaviour
// RULE1 - frequency select low means 19.2 MHz master clock, high means 9.6 MHz
// RULE2 - tap controller steps according to sampled mode select
// RULE3 - serial data in shifts into the selected instruction or data register
// RULE4 - serial data out changes on falling test clock edges
// RULE5 - serial data out is high impedance unless a shift is in progress
// RULE6 - test reset low forces the controller to reset state regardless of test clock
// RULE7 - board pulses or holds test reset low at power-up
// RULE8 - device reset low holds device in reset and low-power standby
// RULE9 - after device reset release with clock running, initialisation runs itself
// RULE10 - initialisation presets every control and status register to defaults
// RULE11 - sixteen-state controller samples mode select and data on rising test clock
`timescale 1ns/1ps
`default_nettype none
module tapcs_top (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire tapcs_pkg::tapcs_pins_t pins_in,
  input  wire logic               device_reset_n,
  input  wire logic               freq_sel,
  output tapcs_pkg::tapcs_tdo_t   tdo_out,
  output logic                    standby_r,
  output logic                    init_busy_r,
  output logic                    regs_preset_r,
  output logic                    mclk_slow_r,
  output logic [3:0]              tap_state_r,
  output logic [3:0]              ir_r
);
  import tapcs_pkg::*;

  // ==========================================================
  // input synchronisers
  // ==========================================================
  logic [3:0] pin_s1_r, pin_s2_r;
  logic [1:0] dev_s1_r, dev_s2_r;
  logic       tck_d_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      dev_s1_r <= 2'h0;
      dev_s2_r <= 2'h0;
      tck_d_r  <= 1'b0;
    end else begin
      pin_s1_r <= pins_in;
      pin_s2_r <= pin_s1_r;
      dev_s1_r <= {device_reset_n, freq_sel};
      dev_s2_r <= dev_s1_r;
      tck_d_r  <= pin_s2_r[3];
    end
  end
  tapcs_pins_t p;
  assign p = pin_s2_r;
  logic tck_rise, tck_fall, trst_act, dev_rst_n_s, fsel_s;
  assign tck_rise    = p.tck & ~tck_d_r;
  assign tck_fall    = ~p.tck & tck_d_r;
  assign trst_act    = ~p.trst_n;
  assign dev_rst_n_s = dev_s2_r[1];
  assign fsel_s      = dev_s2_r[0];

  // ==========================================================
  // tap controller
  // ==========================================================
  function automatic tapcs_state_t tap_next(input tapcs_state_t s, input logic tms);
    case (s)
      TAP_RESET:  tap_next = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_next = TAP_RESET;
    endcase
  endfunction

  tapcs_state_t st_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst || trst_act)  // RULE6
      st_r <= TAP_RESET;
    else if (tck_rise)
      st_r <= tap_next(st_r, p.tms);  // RULE2 RULE11
  end
  assign tap_state_r = st_r;

  // ==========================================================
  // instruction and data registers
  // ==========================================================
  logic [IR_W-1:0] ir_sh_r, ir_q_r;
  logic [ID_W-1:0] dr_sh_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst || trst_act || st_r == TAP_RESET) begin
      ir_sh_r <= IR_RST;
      ir_q_r  <= IR_RST;
      dr_sh_r <= '0;
    end else if (tck_rise) begin
      case (st_r)
        TAP_CAP_IR: ir_sh_r <= IR_CAPTURE;
        TAP_SH_IR:  ir_sh_r <= {p.tdi, ir_sh_r[IR_W-1:1]};  // RULE3
        TAP_UPD_IR: ir_q_r  <= ir_sh_r;
        TAP_CAP_DR: dr_sh_r <= (ir_q_r == IR_IDCODE) ? ID_VALUE : '0;
        TAP_SH_DR: begin
          if (ir_q_r == IR_IDCODE)
            dr_sh_r <= {p.tdi, dr_sh_r[ID_W-1:1]};  // RULE3
          else
            dr_sh_r <= {{(ID_W-1){1'b0}}, p.tdi};  // RULE3
        end
        default: ;
      endcase
    end
  end
  assign ir_r = ir_q_r;

  // serial out changes on falling edge and clears on test reset, driven only while shifting
  always_ff @(posedge core_clk) begin
    if (sys_rst || trst_act) begin
      tdo_out <= '0;
    end else if (tck_fall) begin
      tdo_out.tdo_oe <= (st_r == TAP_SH_IR) || (st_r == TAP_SH_DR);  // RULE5
      tdo_out.tdo    <= (st_r == TAP_SH_IR) ? ir_sh_r[0] : dr_sh_r[0];  // RULE4
    end
  end

  // ==========================================================
  // device reset, standby and initialisation
  // ==========================================================
  logic [INIT_CNT_W-1:0] init_cnt_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !dev_rst_n_s) begin
      standby_r     <= 1'b1;  // RULE8
      init_busy_r   <= 1'b0;
      regs_preset_r <= 1'b0;
      init_cnt_r    <= '0;
    end else if (standby_r) begin
      standby_r   <= 1'b0;
      init_busy_r <= 1'b1;  // RULE9
    end else if (init_busy_r) begin
      if (init_cnt_r == INIT_LAST) begin
        init_busy_r   <= 1'b0;
        regs_preset_r <= 1'b1;  // RULE10
      end else
        init_cnt_r <= init_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      mclk_slow_r <= FSEL_19M2;
    else if (standby_r)
      mclk_slow_r <= (fsel_s == FSEL_9M6);  // RULE1
  end

  // ==========================================================
  // checks
  // ==========================================================
  property p_trst_resets;
    @(posedge core_clk) disable iff (sys_rst) trst_act |=> st_r == TAP_RESET;
  endproperty
  a_trst_resets: assert property (p_trst_resets) else $error("tap not reset"); // RULE6

  property p_step;
    @(posedge core_clk) disable iff (sys_rst || trst_act)
      tck_rise |=> st_r == tap_next($past(st_r), $past(p.tms));
  endproperty
  a_step: assert property (p_step) else $error("bad tap step"); // RULE2

  property p_hold;
    @(posedge core_clk) disable iff (sys_rst || trst_act) !tck_rise |=> $stable(st_r);
  endproperty
  a_hold: assert property (p_hold) else $error("tap moved without edge"); // RULE11

  property p_tdo_edge;
    @(posedge core_clk) disable iff (sys_rst || trst_act) !$past(tck_fall) |-> $stable(tdo_out);
  endproperty
  a_tdo_edge: assert property (p_tdo_edge) else $error("tdo moved off falling edge"); // RULE4

  property p_tdo_z;
    @(posedge core_clk) disable iff (sys_rst || trst_act)
      tck_fall && st_r != TAP_SH_IR && st_r != TAP_SH_DR |=> !tdo_out.tdo_oe;
  endproperty
  a_tdo_z: assert property (p_tdo_z) else $error("tdo driven outside shift"); // RULE5

  property p_tdo_on;
    @(posedge core_clk) disable iff (sys_rst || trst_act)
      tck_fall && (st_r == TAP_SH_IR || st_r == TAP_SH_DR) |=> tdo_out.tdo_oe;
  endproperty
  a_tdo_on: assert property (p_tdo_on) else $error("tdo not driven in shift"); // RULE5

  property p_ir_shift;
    @(posedge core_clk) disable iff (sys_rst || trst_act)
      tck_rise && st_r == TAP_SH_IR |=> ir_sh_r[IR_W-1] == $past(p.tdi);
  endproperty
  a_ir_shift: assert property (p_ir_shift) else $error("tdi not shifted"); // RULE3

  property p_standby;
    @(posedge core_clk) disable iff (sys_rst) !dev_rst_n_s |=> standby_r && !regs_preset_r;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby in reset"); // RULE8

  sequence s_release;
    $rose(dev_rst_n_s) ##1 init_busy_r;
  endsequence
  property p_init;
    @(posedge core_clk) disable iff (sys_rst || !dev_rst_n_s)
      s_release |-> ##[1:40] regs_preset_r;
  endproperty
  a_init: assert property (p_init) else $error("init did not finish"); // RULE9 RULE10

endmodule // tapcs_top
`default_nettype wire

// ===== testbench/tapcs_tester.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// scan tester and board reset/clock-select model
module tapcs_tester
  import tapcs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire tapcs_tdo_t  tdo_in,
  output tapcs_pins_t      pins,
  output logic             device_reset_n,
  output logic             freq_sel
);
  initial begin
    pins.tck    = 1'b0;
    pins.tms    = 1'b1;
    pins.tdi    = 1'b1;
    pins.trst_n = 1'b0;
    device_reset_n = 1'b0;
    freq_sel = FSEL_9M6;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one test clock period of 128 ns; tck stands still between calls
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    pins.tck = 1'b0;
    pins.tms = tms;
    pins.tdi = tdi;
    wait_cyc(8);
    // an undriven line reads as the inverse of the last bit
    tdo = tdo_in.tdo_oe ? tdo_in.tdo : ~tdo_in.tdo;
    pins.tck = 1'b1;
    wait_cyc(8);
  endtask
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = 32'h0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask
endmodule // tapcs_tester
`default_nettype wire

// ===== testbench/tapcs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tapcs_top_tb;
  import tapcs_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  tapcs_pins_t pins;
  tapcs_tdo_t  tdo_out;
  logic        device_reset_n, freq_sel, standby_r, init_busy_r, regs_preset_r, mclk_slow_r;
  logic [3:0]  tap_state_r, ir_r;
  logic [31:0] d;
  logic        b;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  tapcs_tester u_tester (.core_clk(core_clk), .tdo_in(tdo_out), .pins(pins),
    .device_reset_n(device_reset_n), .freq_sel(freq_sel));
  tapcs_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .pins_in(pins),
    .device_reset_n(device_reset_n), .freq_sel(freq_sel), .tdo_out(tdo_out),
    .standby_r(standby_r), .init_busy_r(init_busy_r), .regs_preset_r(regs_preset_r),
    .mclk_slow_r(mclk_slow_r), .tap_state_r(tap_state_r), .ir_r(ir_r));
  // ==========================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ==========================================
  // scenarios
  task automatic t_init(input logic fs);
    int n;
    u_tester.device_reset_n = 1'b0;
    u_tester.freq_sel = fs;
    u_tester.wait_cyc(10);
    check(32'({standby_r, regs_preset_r}), 32'h2);
    u_tester.pins.trst_n = 1'b1;
    u_tester.device_reset_n = 1'b1;
    n = 0;
    while (init_busy_r !== 1'b1 && n < 10) begin u_tester.wait_cyc(1); n++; end
    n = 0;
    while (init_busy_r === 1'b1 && n < 100) begin u_tester.wait_cyc(1); n++; end
    check(32'(n), 32'(INIT_CYCLES));
    check(32'({standby_r, regs_preset_r}), 32'h1);
    check(32'(mclk_slow_r), 32'(fs == FSEL_9M6));
    $display("test init done");
  endtask
  task automatic t_idcode();
    // idle, select, capture, then into shift before the first bit
    u_tester.step(1'b0, 1'b1, b);
    u_tester.step(1'b1, 1'b1, b);
    u_tester.step(1'b0, 1'b1, b);
    u_tester.step(1'b0, 1'b1, b);
    u_tester.shift(32, 32'h0, d);
    check(d, ID_VALUE);
    u_tester.step(1'b1, 1'b1, b);
    check(32'(tdo_out.tdo_oe), 32'h0);
    u_tester.step(1'b0, 1'b1, b);
    check(32'(tap_state_r), 32'(TAP_IDLE));
    $display("test idcode done");
  endtask
  task automatic t_bypass();
    u_tester.step(1'b1, 1'b1, b);
    u_tester.step(1'b1, 1'b1, b);
    u_tester.step(1'b0, 1'b1, b);
    u_tester.step(1'b0, 1'b1, b);
    u_tester.shift(4, 32'(IR_BYPASS), d);
    check(d, 32'(IR_CAPTURE));
    u_tester.step(1'b1, 1'b1, b);
    u_tester.step(1'b0, 1'b1, b);
    check(32'(ir_r), 32'(IR_BYPASS));
    u_tester.step(1'b1, 1'b1, b);
    u_tester.step(1'b0, 1'b1, b);
    u_tester.step(1'b0, 1'b1, b);
    u_tester.shift(2, 32'h1, d);
    check(d, 32'h2);
    u_tester.step(1'b1, 1'b1, b);
    $display("test bypass done");
  endtask
  task automatic t_trst();
    // park in a data shift with the output driven, then pull test reset
    u_tester.step(1'b1, 1'b1, b);
    u_tester.step(1'b0, 1'b1, b);
    u_tester.step(1'b0, 1'b1, b);
    u_tester.step(1'b0, 1'b1, b);
    check(32'({tap_state_r, tdo_out.tdo_oe}), 32'({TAP_SH_DR, 1'b1}));
    u_tester.pins.trst_n = 1'b0;
    u_tester.wait_cyc(6);
    check(32'({tap_state_r, ir_r}), 32'({TAP_RESET, IR_RST}));
    check(32'(tdo_out.tdo_oe), 32'h0);
    u_tester.pins.trst_n = 1'b1;
    $display("test test-reset done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    t_init(FSEL_9M6);
    t_idcode();
    t_bypass();
    t_trst();
    t_init(FSEL_19M2);
    tally_and_finish();
  end
endmodule // tapcs_top_tb
`default_nettype wire
